// ---- rtl/dcwb_data_cache.v ----
// Purpose: Two-way data cache with buffered refill and a write-through store buffer.
// Assumes: CPU and memory sides are logic on ref_clk; requests held until answered.
// Notes:   Registers reached over AXI4-Lite; all outputs come from flip-flops.
`timescale 1ns/100ps
`include "dcwb_defines.vh"
module dcwb_data_cache (
    input wire ref_clk,
    input wire rst_n,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire cpuReq,
    input wire cpuWr,
    input wire [31:0] cpuAddr,
    input wire [31:0] cpuWdata,
    input wire [3:0] cpuBe,
    input wire cpuCacheable,
    input wire cpuXlate,
    input wire cpuTlbHit,
    input wire cacheFlushOp,
    output reg cpuDone_r,
    output reg cpuTrap_r,
    output reg [31:0] cpuRdata_r,
    output reg memReq_r,
    output reg memWe_r,
    output reg [31:0] memAddr_r,
    output reg [31:0] memWdata_r,
    output reg [3:0] memBe_r,
    output reg memUrgent_r,
    input wire memAck,
    input wire [31:0] memRdata
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_CRIT = 4'h2;
    localparam [3:0] ST_SINGLE = 4'h4;
    localparam [3:0] ST_UNCST = 4'h8;
    localparam [1:0] SRC_WB = 2'h0;
    localparam [1:0] SRC_RF = 2'h1;
    localparam [1:0] SRC_CPU = 2'h2;

    reg [127:0] dataMem [0:127];
    reg [21:0] tagMem [0:127];
    reg [127:0] valid_r;
    reg [3:0] state_r;
    reg [31:0] ptr_r;
    reg [1:0] ctrl_r;
    reg [7:0] lfsr_r;
    reg [1:0] memSrc_r;
    reg rfActive_r;
    reg [2:0] rfCnt_r;
    reg [1:0] rfWord_r;
    reg [6:0] rfBlk_r;
    reg [21:0] rfTag_r;
    reg [31:0] rfBuf_r [0:3];
    integer k;

    // ----------------------------------------------------------------
    // Lookup
    // ----------------------------------------------------------------
    wire ctrlDisable = ctrl_r[`DCWB_CTL_DISABLE];
    wire ctrlLock = ctrl_r[`DCWB_CTL_LOCK];
    wire [5:0] idx = cpuAddr[9:4];
    wire [1:0] wsel = cpuAddr[3:2];
    wire [6:0] blk0 = {1'b0, idx};
    wire [6:0] blk1 = {1'b1, idx};
    wire tlbOk = !cpuXlate || cpuTlbHit;
    wire v0 = valid_r[blk0];
    wire v1 = valid_r[blk1];
    wire hit0 = v0 && tagMem[blk0] == cpuAddr[31:10] && !ctrlDisable && tlbOk;
    wire hit1 = v1 && tagMem[blk1] == cpuAddr[31:10] && !ctrlDisable && tlbOk;
    wire hitAny = hit0 || hit1;
    wire [6:0] hitBlk = hit1 ? blk1 : blk0;
    wire [127:0] hitLine = dataMem[hitBlk];
    wire [31:0] hitWord = hitLine[{wsel, 5'h00} +: 32];
    wire cacheOn = cpuCacheable && !ctrlDisable;
    wire noAlloc = ctrlLock && v0 && v1;
    wire vicCol = v0 && (!v1 || lfsr_r[0]);
    wire take = cpuReq && !cpuDone_r && state_r == ST_IDLE;
    wire flushOk = !(ctrlLock && !ctrlDisable);

    // ----------------------------------------------------------------
    // Write buffer
    // ----------------------------------------------------------------
    wire wbValid, wbFull, wbEmpty, wbMatch;
    wire [31:0] wbAddr, wbData;
    wire [3:0] wbBe;
    wire [1:0] wbCount;
    wire memDone = memReq_r && memAck;
    wire wbPop = memDone && memSrc_r == SRC_WB;
    wire cachedSt = take && cpuWr && tlbOk && cacheOn;
    wire wbPush = cachedSt && !wbFull;
    wire [5:0] cmpIdx = rfActive_r ? rfBlk_r[5:0] : idx;

    dcwb_write_buffer dcwb_write_buffer_i (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .push(wbPush),
        .pushAddr(cpuAddr),
        .pushData(cpuWdata),
        .pushBe(cpuBe),
        .pop(wbPop),
        .cmpIdx(cmpIdx),
        .headValid(wbValid),
        .headAddr(wbAddr),
        .headData(wbData),
        .headBe(wbBe),
        .full(wbFull),
        .empty(wbEmpty),
        .idxMatch(wbMatch),
        .count(wbCount)
    );

    // ----------------------------------------------------------------
    // Memory request selection
    // ----------------------------------------------------------------
    wire rfWant = rfActive_r && rfCnt_r != `DCWB_BLOCK_WORDS && !wbMatch;
    wire cpuWant = state_r == ST_SINGLE || state_r == ST_UNCST;
    wire blockWrite = rfActive_r && rfCnt_r == `DCWB_BLOCK_WORDS && !(take && hitAny);
    reg [1:0] selSrc;
    reg selGo;

    always @* begin
        selGo = 1'b1;
        selSrc = SRC_WB;
        if (wbValid && (memUrgent_r || (rfActive_r && wbMatch))) begin
            selSrc = SRC_WB;
        end else if (cpuWant) begin
            selSrc = SRC_CPU;
        end else if (rfWant) begin
            selSrc = SRC_RF;
        end else if (wbValid) begin
            selSrc = SRC_WB;
        end else begin
            selGo = 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            memReq_r <= 1'b0;
            memWe_r <= 1'b0;
            memAddr_r <= 32'h00000000;
            memWdata_r <= 32'h00000000;
            memBe_r <= 4'h0;
            memSrc_r <= SRC_WB;
        end else if (memReq_r) begin
            if (memAck) begin
                memReq_r <= 1'b0;
            end
        end else if (selGo) begin
            memReq_r <= 1'b1;
            memSrc_r <= selSrc;
            case (selSrc)
                SRC_RF: begin
                    memWe_r <= 1'b0;
                    memAddr_r <= {rfTag_r, rfBlk_r[5:0], rfWord_r, 2'h0};
                    memBe_r <= 4'hF;
                end
                SRC_CPU: begin
                    memWe_r <= state_r == ST_UNCST;
                    memAddr_r <= cpuAddr;
                    memWdata_r <= cpuWdata;
                    memBe_r <= cpuWr ? cpuBe : 4'hF;
                end
                default: begin
                    memWe_r <= 1'b1;
                    memAddr_r <= wbAddr;
                    memWdata_r <= wbData;
                    memBe_r <= wbBe;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Processor sequencing and refill engine
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cpuDone_r <= 1'b0;
            cpuTrap_r <= 1'b0;
            cpuRdata_r <= 32'h00000000;
            memUrgent_r <= 1'b0;
            rfActive_r <= 1'b0;
            rfCnt_r <= 3'h0;
            rfWord_r <= 2'h0;
            rfBlk_r <= 7'h00;
            rfTag_r <= 22'h000000;
            lfsr_r <= `DCWB_LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
            cpuDone_r <= 1'b0;
            cpuTrap_r <= 1'b0;
            memUrgent_r <= cachedSt && wbFull;
            if (memDone && memSrc_r == SRC_RF) begin
                rfBuf_r[rfWord_r] <= memRdata;
                rfWord_r <= rfWord_r + 2'h1;
                rfCnt_r <= rfCnt_r + 3'h1;
            end
            if (blockWrite) begin
                rfActive_r <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    if (take && !tlbOk) begin
                        cpuTrap_r <= 1'b1;
                        cpuDone_r <= 1'b1;
                    end else if (take && cpuWr) begin
                        if (cacheOn) begin
                            cpuDone_r <= !wbFull;
                        end else if (wbEmpty) begin
                            state_r <= ST_UNCST;
                        end
                    end else if (take && hitAny) begin
                        cpuRdata_r <= hitWord;
                        cpuDone_r <= 1'b1;
                    end else if (take && !rfActive_r) begin
                        if (!cacheOn) begin
                            if (wbEmpty) begin
                                state_r <= ST_SINGLE;
                            end
                        end else if (noAlloc) begin
                            if (!wbMatch) begin
                                state_r <= ST_SINGLE;
                            end
                        end else begin
                            rfActive_r <= 1'b1;
                            rfBlk_r <= {vicCol, idx};
                            rfTag_r <= cpuAddr[31:10];
                            rfWord_r <= wsel;
                            rfCnt_r <= 3'h0;
                            state_r <= ST_CRIT;
                        end
                    end
                end
                ST_CRIT: begin
                    if (memDone && memSrc_r == SRC_RF) begin
                        cpuRdata_r <= memRdata;
                        cpuDone_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_SINGLE, ST_UNCST: begin
                    if (memDone && memSrc_r == SRC_CPU) begin
                        cpuRdata_r <= memRdata;
                        cpuDone_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register slave
    // ----------------------------------------------------------------
    wire [6:0] swBlk = ptr_r[`DCWB_PTR_COL:`DCWB_PTR_IDX_LO];
    wire [1:0] swWord = ptr_r[`DCWB_PTR_WORD_HI:`DCWB_PTR_WORD_LO];
    wire swTagSel = ptr_r[`DCWB_PTR_FIELD_SELECT];
    wire [127:0] swLine = dataMem[swBlk];
    wire [31:0] swTagWord = {tagMem[swBlk], 7'h00, valid_r[swBlk], 2'h0};
    wire [31:0] swRead = swTagSel ? swTagWord : swLine[{swWord, 5'h00} +: 32];
    wire wrFire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    wire rdFire = s_axi_arready && s_axi_arvalid;
    wire wrMapped = s_axi_awaddr == `DCWB_OFS_POINTER || s_axi_awaddr == `DCWB_OFS_TRANSFER
        || s_axi_awaddr == `DCWB_OFS_CONTROL || s_axi_awaddr == `DCWB_OFS_STATUS;
    wire xferWr = wrFire && s_axi_awaddr == `DCWB_OFS_TRANSFER && s_axi_wstrb == 4'hF;
    reg [31:0] rdVal;
    reg rdOk;

    always @* begin
        rdOk = 1'b1;
        case (s_axi_araddr)
            `DCWB_OFS_POINTER: rdVal = ptr_r;
            `DCWB_OFS_TRANSFER: rdVal = swRead;
            `DCWB_OFS_CONTROL: rdVal = {30'h00000000, ctrl_r};
            `DCWB_OFS_STATUS: rdVal = {27'h0000000, wbCount, rfActive_r, state_r == ST_IDLE, wbFull};
            default: begin
                rdVal = 32'h00000000;
                rdOk = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DCWB_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `DCWB_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            ptr_r <= 32'h00000000;
            ctrl_r <= `DCWB_CTL_RESET;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrMapped ? `DCWB_RESP_OKAY : `DCWB_RESP_SLVERR;
                if (s_axi_awaddr == `DCWB_OFS_POINTER) begin
                    ptr_r <= s_axi_wdata & 32'h000007FD;
                end
                if (s_axi_awaddr == `DCWB_OFS_CONTROL && s_axi_wstrb[0]) begin
                    ctrl_r <= s_axi_wdata[1:0];
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rdFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdVal;
                s_axi_rresp <= rdOk ? `DCWB_RESP_OKAY : `DCWB_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Valid flags; a set in the same cycle as a flush wins
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            valid_r <= 128'h0;
        end else begin
            if (cacheFlushOp && flushOk) begin
                valid_r <= 128'h0;
            end
            if (take && !cpuWr && tlbOk && !hitAny && !rfActive_r && cacheOn && !noAlloc) begin
                valid_r[{vicCol, idx}] <= 1'b0;
            end
            if (xferWr && swTagSel) begin
                valid_r[swBlk] <= s_axi_wdata[`DCWB_TAG_VALID];
            end
            if (blockWrite) begin
                valid_r[rfBlk_r] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Arrays
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (take && !cpuWr && tlbOk && !hitAny && !rfActive_r && cacheOn && !noAlloc) begin
            tagMem[{vicCol, idx}] <= cpuAddr[31:10];
        end
        if (wbPush && hitAny) begin
            for (k = 0; k < 4; k = k + 1) begin
                if (cpuBe[k]) begin
                    dataMem[hitBlk][{wsel, 5'h00} + k * 8 +: 8] <= cpuWdata[k * 8 +: 8];
                end
            end
        end
        if (blockWrite) begin
            dataMem[rfBlk_r] <= {rfBuf_r[3], rfBuf_r[2], rfBuf_r[1], rfBuf_r[0]};
        end
        if (xferWr) begin
            if (swTagSel) begin
                tagMem[swBlk] <= s_axi_wdata[`DCWB_TAG_HI:`DCWB_TAG_LO];
            end else begin
                dataMem[swBlk][{swWord, 5'h00} +: 32] <= s_axi_wdata;
            end
        end
    end
endmodule

// ---- include/dcwb_defines.vh ----
// Purpose: Register map, field positions and fixed codes of the data cache block.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef DCWB_DEFINES_VH
`define DCWB_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DCWB_OFS_POINTER 4'h0
`define DCWB_OFS_TRANSFER 4'h4
`define DCWB_OFS_CONTROL 4'h8
`define DCWB_OFS_STATUS 4'hC

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCWB_PTR_COL 10
`define DCWB_PTR_IDX_HI 9
`define DCWB_PTR_IDX_LO 4
`define DCWB_PTR_WORD_HI 3
`define DCWB_PTR_WORD_LO 2
`define DCWB_PTR_FIELD_SELECT 0
`define DCWB_TAG_HI 31
`define DCWB_TAG_LO 10
`define DCWB_TAG_VALID 2
`define DCWB_CTL_DISABLE 0
`define DCWB_CTL_LOCK 1

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define DCWB_CTL_RESET 2'h0
`define DCWB_LFSR_SEED 8'hA5
`define DCWB_RESP_OKAY 2'h0
`define DCWB_RESP_SLVERR 2'h2
`define DCWB_BLOCK_WORDS 3'h4

`endif

// ---- rtl/dcwb_write_buffer.v ----
// Purpose: Two-entry store FIFO between the cache and external memory.
// Assumes: Push only when full is low; pop only when the head is valid.
// Notes:   A pop and a push may share one cycle.
`timescale 1ns/100ps
`include "dcwb_defines.vh"
module dcwb_write_buffer (
    input wire ref_clk,
    input wire rst_n,
    input wire push,
    input wire [31:0] pushAddr,
    input wire [31:0] pushData,
    input wire [3:0] pushBe,
    input wire pop,
    input wire [5:0] cmpIdx,
    output wire headValid,
    output wire [31:0] headAddr,
    output wire [31:0] headData,
    output wire [3:0] headBe,
    output wire full,
    output wire empty,
    output wire idxMatch,
    output wire [1:0] count
);
    reg [31:0] addr0_r, addr1_r, data0_r, data1_r;
    reg [3:0] be0_r, be1_r;
    reg v0_r, v1_r;
    wire occ0 = pop ? v1_r : v0_r;

    // ----------------------------------------------------------------
    // Entry update
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
        end else begin
            if (pop) begin
                addr0_r <= addr1_r;
                data0_r <= data1_r;
                be0_r <= be1_r;
                v0_r <= v1_r;
                v1_r <= 1'b0;
            end
            if (push) begin
                if (!occ0) begin
                    addr0_r <= pushAddr;
                    data0_r <= pushData;
                    be0_r <= pushBe;
                    v0_r <= 1'b1;
                end else begin
                    addr1_r <= pushAddr;
                    data1_r <= pushData;
                    be1_r <= pushBe;
                    v1_r <= 1'b1;
                end
            end
        end
    end

    assign headValid = v0_r;
    assign headAddr = addr0_r;
    assign headData = data0_r;
    assign headBe = be0_r;
    assign full = v0_r & v1_r;
    assign empty = ~v0_r & ~v1_r;
    assign count = {1'b0, v0_r} + {1'b0, v1_r};
    assign idxMatch = (v0_r && addr0_r[9:4] == cmpIdx) || (v1_r && addr1_r[9:4] == cmpIdx);
endmodule

// ---- bench/dcwb_data_cache_properties.sv ----
// Purpose: Port checks for the data cache.
// Assumes: Bound to the cache from the bench top.
// Notes: One clock domain.
`timescale 1ns/100ps
module dcwb_data_cache_properties (
    input wire ref_clk,
    input wire rst_n,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire cpuReq,
    input wire cpuXlate,
    input wire cpuTlbHit,
    input wire cpuDone_r,
    input wire cpuTrap_r,
    input wire memReq_r,
    input wire memWe_r,
    input wire [31:0] memAddr_r,
    input wire [31:0] memWdata_r,
    input wire [3:0] memBe_r,
    input wire memUrgent_r,
    input wire memAck
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence memStall;
        memReq_r && !memAck;
    endsequence
    sequence trapReq;
        $rose(cpuReq) && cpuXlate && !cpuTlbHit && !memReq_r;
    endsequence
    a_trap_done: assert property (cpuTrap_r |-> cpuDone_r)
        else $error("trap without done");
    a_trap_fast: assert property (trapReq |=> cpuTrap_r)
        else $error("trap late");
    a_done_pulse: assert property (cpuDone_r |=> !cpuDone_r)
        else $error("done too long");
    a_mem_hold: assert property (memStall |=> memReq_r && $stable(memAddr_r) && $stable(memBe_r))
        else $error("request not held");
    a_mem_drop: assert property (memReq_r && memAck |=> !memReq_r)
        else $error("request not dropped");
    a_wr_hold: assert property (memStall and memWe_r |=> $stable(memWdata_r) && memWe_r)
        else $error("write data moved");
    a_urgent_head: assert property ($rose(memReq_r) && $past(memUrgent_r) |-> memWe_r)
        else $error("urgent not a write");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data moved");
endmodule

// ---- bench/dcwb_mem_model.sv ----
// Purpose: Memory side model with log of read addresses and a count and last data of writes.
// Assumes: Requests held until acknowledged.
// Notes: Slow mode withholds the answer as a pre-emption would.
`timescale 1ns/100ps
module dcwb_mem_model (
    input wire ref_clk,
    input wire memReq,
    input wire memWe,
    input wire [31:0] memAddr,
    input wire [31:0] memWdata,
    input wire slow,
    output reg memAck = 1'h0,
    output reg [31:0] memRdata = 32'h0
);
    reg [3:0] waitCnt = 4'h0;
    reg [31:0] rdLog [0:15];
    reg [31:0] lastWd = 32'h0;
    integer rdCnt = 0;
    integer wrCnt = 0;
    always @(posedge ref_clk) begin
        memAck <= 1'h0;
        memRdata <= ~memRdata;
        if (!memReq || memAck) begin
            waitCnt <= 4'h0;
        end else if (waitCnt < (slow ? 4'h6 : 4'h1)) begin
            waitCnt <= waitCnt + 4'h1;
        end else begin
            memAck <= 1'h1;
            if (memWe) begin
                lastWd <= memWdata;
                wrCnt <= wrCnt + 1;
            end else begin
                memRdata <= memAddr ^ 32'hA5A50000;
                rdLog[rdCnt[3:0]] <= memAddr;
                rdCnt <= rdCnt + 1;
            end
        end
    end
endmodule

// ---- bench/dcwb_data_cache_tb.sv ----
// Purpose: Self-checking bench for the data cache.
// Assumes: Memory answers with address-derived words.
// Notes: Table rows first, then hand tests.
`timescale 1ns/100ps
module dcwb_data_cache_tb;
    typedef struct packed {reg w; reg [31:0] a, d; reg [2:0] at; reg [31:0] e; reg t; integer c;} dcwb_row_t;
    dcwb_row_t rows [0:5];
    reg ref_clk = 1'h0;
    reg rst_n = 1'h0;
    reg [3:0] awAddr = 4'h0, arAddr = 4'h0, wStrb = 4'hF;
    reg awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
    reg cpuReq = 1'h0, cpuWr = 1'h0, cpuCacheable = 1'h0, cpuXlate = 1'h0, cpuTlbHit = 1'h0;
    reg cacheFlushOp = 1'h0, slow = 1'h0, trapGot, seenUrg;
    reg [31:0] wData = 32'h0, cpuAddr = 32'h0, cpuWdata = 32'h0, got;
    reg [1:0] rr;
    wire awReady, wReady, bValid, arReady, rValid, cpuDone_r, cpuTrap_r, memReq_r, memWe_r;
    wire memUrgent_r, memAck;
    wire [1:0] bResp, rResp;
    wire [31:0] rData, cpuRdata_r, memAddr_r, memWdata_r, memRdata;
    wire [3:0] memBe_r;
    integer miscompares = 0, cmp_count = 0, n, i, w0;
    always #25 ref_clk = ~ref_clk;
    dcwb_data_cache dcwb_data_cache_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .cpuReq(cpuReq), .cpuWr(cpuWr), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuBe(4'hF),
        .cpuCacheable(cpuCacheable), .cpuXlate(cpuXlate), .cpuTlbHit(cpuTlbHit),
        .cacheFlushOp(cacheFlushOp), .cpuDone_r(cpuDone_r), .cpuTrap_r(cpuTrap_r),
        .cpuRdata_r(cpuRdata_r), .memReq_r(memReq_r), .memWe_r(memWe_r), .memAddr_r(memAddr_r),
        .memWdata_r(memWdata_r), .memBe_r(memBe_r), .memUrgent_r(memUrgent_r), .memAck(memAck),
        .memRdata(memRdata));
    dcwb_mem_model dcwb_mem_model_i (.ref_clk(ref_clk), .memReq(memReq_r), .memWe(memWe_r),
        .memAddr(memAddr_r), .memWdata(memWdata_r), .slow(slow), .memAck(memAck),
        .memRdata(memRdata));
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task tmo;
        if (n >= 99) begin
            miscompares = miscompares + 1;
            $display("BAD %0t timeout", $time);
            finish_test;
        end
    endtask
    task axiWr(input [3:0] a, input [31:0] d);
        @(posedge ref_clk);
        {awAddr, wData, awValid, wValid, bReady} <= {a, d, 3'h7};
        n = 0;
        do @(posedge ref_clk) n = n + 1; while (awReady !== 1'h1 && n < 50);
        {awValid, wValid} <= 2'h0;
        while (bValid !== 1'h1 && n < 99) @(posedge ref_clk) n = n + 1;
        bReady <= 1'h0;
        tmo;
    endtask
    task axiRd(input [3:0] a);
        @(posedge ref_clk);
        {arAddr, arValid, rReady} <= {a, 2'h3};
        n = 0;
        do @(posedge ref_clk) n = n + 1; while (arReady !== 1'h1 && n < 50);
        arValid <= 1'h0;
        while (rValid !== 1'h1 && n < 99) @(posedge ref_clk) n = n + 1;
        {got, rr} = {rData, rResp};
        rReady <= 1'h0;
        tmo;
    endtask
    task cpuAcc(input w, input [31:0] a, input [31:0] d, input [2:0] at);
        @(posedge ref_clk);
        {cpuReq, cpuWr, cpuAddr, cpuWdata, cpuCacheable, cpuXlate, cpuTlbHit} <= {1'h1, w, a, d, at};
        {n, seenUrg} = 33'h0;
        do @(posedge ref_clk) {n, seenUrg} = {n + 1, seenUrg | memUrgent_r};
        while (cpuDone_r !== 1'h1 && n < 99);
        {got, trapGot} = {cpuRdata_r, cpuTrap_r};
        cpuReq <= 1'h0;
        tmo;
    endtask
    initial begin
        rows[0] = '{1'h0, 32'h1238, 32'h0, 3'h4, 32'hA5A51238, 1'h0, 0};
        rows[1] = '{1'h0, 32'h1234, 32'h0, 3'h4, 32'hA5A51234, 1'h0, 0};
        rows[2] = '{1'h1, 32'h1234, 32'h11112222, 3'h4, 32'h0, 1'h0, 2};
        rows[3] = '{1'h0, 32'h1234, 32'h0, 3'h4, 32'h11112222, 1'h0, 2};
        rows[4] = '{1'h0, 32'h1238, 32'h0, 3'h6, 32'h0, 1'h1, 2};
        rows[5] = '{1'h0, 32'h80000010, 32'h0, 3'h0, 32'h25A50010, 1'h0, 0};
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'h1;
        for (i = 0; i < 6; i = i + 1) begin
            cpuAcc(rows[i].w, rows[i].a, rows[i].d, rows[i].at);
            chk(trapGot, rows[i].t);
            if (!rows[i].w && !rows[i].t) chk(got, rows[i].e);
            if (rows[i].c != 0) chk(n, rows[i].c);
        end
        for (i = 0; i < 4; i = i + 1) chk(dcwb_mem_model_i.rdLog[i], 32'h1230 + ((i + 2) % 4) * 4);
        chk(dcwb_mem_model_i.lastWd, 32'h11112222);
        $display("table rows done");
        axiWr(4'h0, 32'h231);
        axiRd(4'h4);
        chk(got, 32'h1004);
        axiWr(4'h0, 32'h234);
        axiRd(4'h4);
        chk(got, 32'h11112222);
        axiWr(4'h4, 32'hCAFE0001);
        wStrb <= 4'h3;
        axiWr(4'h4, 32'h0);
        wStrb <= 4'hF;
        cpuAcc(1'h0, 32'h1234, 32'h0, 3'h4);
        chk(got, 32'hCAFE0001);
        axiRd(4'h2);
        chk(rr, 2'h2);
        $display("register test done");
        @(posedge ref_clk) cacheFlushOp <= 1'h1;
        @(posedge ref_clk) cacheFlushOp <= 1'h0;
        axiWr(4'h0, 32'h231);
        axiRd(4'h4);
        chk(got, 32'h1000);
        $display("flush test done");
        axiWr(4'h8, 32'h1);
        cpuAcc(1'h0, 32'h1238, 32'h0, 3'h4);
        chk(got, 32'hA5A51238);
        axiWr(4'h8, 32'h0);
        cpuAcc(1'h0, 32'h1234, 32'h0, 3'h4);
        chk(got, 32'hA5A51234);
        repeat (20) @(posedge ref_clk);
        axiRd(4'h4);
        chk(got, 32'h1004);
        rst_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        chk({memReq_r, cpuDone_r, bValid, rValid}, 4'h0);
        rst_n <= 1'h1;
        axiWr(4'h0, 32'h231);
        axiRd(4'h4);
        chk(got, 32'h1000);
        $display("disable and reset test done");
        slow <= 1'h1;
        w0 = dcwb_mem_model_i.wrCnt;
        for (i = 0; i < 3; i = i + 1) begin
            cpuAcc(1'h1, 32'h2000 + i * 16, i, 3'h4);
            if (i < 2) chk(n, 2);
        end
        chk(seenUrg, 1'h1);
        n = 0;
        while (dcwb_mem_model_i.wrCnt < w0 + 3 && n < 99) @(posedge ref_clk) n = n + 1;
        chk(dcwb_mem_model_i.wrCnt, w0 + 3);
        $display("full buffer test done");
        finish_test;
    end
endmodule
bind dcwb_data_cache dcwb_data_cache_properties dcwb_data_cache_properties_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .cpuReq(cpuReq), .cpuXlate(cpuXlate), .cpuTlbHit(cpuTlbHit),
    .cpuDone_r(cpuDone_r), .cpuTrap_r(cpuTrap_r), .memReq_r(memReq_r), .memWe_r(memWe_r),
    .memAddr_r(memAddr_r), .memWdata_r(memWdata_r), .memBe_r(memBe_r),
    .memUrgent_r(memUrgent_r), .memAck(memAck));
